/* inc/hbvef_params.svh */
/*
  Constants for the host buffer vector and error flag block: register
  offsets, error bit positions, reset values, masks and counts.
  Assumes inclusion by the package and by the design module only.
*/
`ifndef HBVEF_PARAMS_SVH
`define HBVEF_PARAMS_SVH

// ----------------------------------------
// register offsets and reserved range
// ----------------------------------------
`define HBVEF_OFF_ERR 16'h0012
`define HBVEF_OFF_RXV 16'h0024
`define HBVEF_OFF_TXV 16'h0026
`define HBVEF_RSV_LO 16'h0400
`define HBVEF_RSV_HI 16'h1fff

// ----------------------------------------
// error flag bit positions
// ----------------------------------------
`define HBVEF_B_LOST 0
`define HBVEF_B_RCFG 1
`define HBVEF_B_BUSY 3
`define HBVEF_B_DBL 4
`define HBVEF_B_RBL 6
`define HBVEF_B_TBL 7
`define HBVEF_B_FBL 8
`define HBVEF_B_EFL 9
`define HBVEF_B_BUL 10
`define HBVEF_B_MDP 11
`define HBVEF_B_SPL 12
`define HBVEF_B_NMS 13
`define HBVEF_B_NMN 14
`define HBVEF_B_ILA 15

// ----------------------------------------
// reset values, masks, counts
// ----------------------------------------
`define HBVEF_ERR_RST 16'h0000
`define HBVEF_ERR_MASK 16'hffdb
`define HBVEF_VEC_RST 6'h00
`define HBVEF_VEC_NONE 6'h00
`define HBVEF_RD_ZERO 16'h0000
`define HBVEF_NBUF 59
`define HBVEF_ERR_W 16

`endif

/* inc/hbvef_pkg.sv */
/*
  Types shared by the host buffer vector and error flag block.
  Assumes hbvef_params.svh is on the include path.
*/
`default_nettype none
`include "hbvef_params.svh"

package hbvef_pkg;
  typedef logic [5:0] hbvef_vec_t;
  typedef logic [15:0] hbvef_word_t;
  typedef logic [`HBVEF_NBUF-1:0] hbvef_bufmask_t;
  typedef logic [6:0] hbvef_plen_t;
endpackage

`default_nettype wire

/* hw/hbvef_top.sv */
/*
  Host-interface status logic: receive and transmit buffer vectors and
  the write-one-to-clear host-interface error flags, with the lock,
  payload-length, reconfiguration, window and management checks that
  feed them. Assumes one core clock, a one-cycle microtick strobe,
  one-cycle host read/write strobes on the parallel port, and buffer
  interrupt flag and enable vectors supplied by the buffer store.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hbvef_params.svh"

module hbvef_top
  import hbvef_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // parallel host port
  input wire hbvef_word_t host_addr,
  input wire hbvef_word_t host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_byte,
  output hbvef_word_t host_rdata,
  output logic host_rack,
  // protocol engine state
  input wire logic utick,
  input wire logic config_exit,
  // buffer interrupt flags and enables
  input wire hbvef_bufmask_t buffer_interrupt_flag,
  input wire hbvef_bufmask_t buffer_interrupt_enable,
  input wire hbvef_bufmask_t buf_is_rx,
  // host lock requests
  input wire logic lock_req,
  input wire logic lock_to_rx,
  input wire logic lock_to_tx,
  input wire logic lock_dev_busy,
  input wire logic lock_double_dev_part,
  input wire logic lock_fifo,
  input wire logic lock_via_buf0,
  input wire logic fifo_empty,
  input wire logic host_rx_held,
  input wire logic host_tx_held,
  output logic lock_grant,
  // reconfiguration and payload length writes
  input wire logic reconfig_req,
  input wire logic reconfig_from_dyn,
  input wire logic reconfig_to_static,
  output logic reconfig_accept,
  input wire logic plen_wr,
  input wire logic plen_dynamic,
  input wire hbvef_plen_t plen_value,
  input wire hbvef_plen_t dynamic_payload_limit,
  input wire hbvef_plen_t static_payload_length,
  output logic plen_accept,
  // active buffer window access
  input wire logic win_access,
  input wire logic win_locked,
  output logic win_allow,
  // received frames
  input wire logic rx_frame_valid,
  input wire logic rx_target_locked,
  output logic frame_discard_first,
  input wire logic nm_frame,
  input wire logic nm_null,
  input wire logic nm_too_short,
  output logic nm_apply,
  // error indication to the interrupt status word
  output logic host_interface_error_irq_flag
);

  // ----------------------------------------
  // lowest set index, used for both vectors
  // ----------------------------------------
  function automatic hbvef_vec_t lowest_idx(input hbvef_bufmask_t m);
    hbvef_vec_t r;
    logic found;
    r = `HBVEF_VEC_NONE;
    found = 1'b0;
    for (int i = 0; i < `HBVEF_NBUF; i++) begin
      if (m[i] && !found) begin
        r = 6'(i);
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // buffer vectors
  // ----------------------------------------
  hbvef_vec_t rxv_q, rxv_d, txv_q, txv_d;
  hbvef_bufmask_t pend;
  wire hbvef_vec_t rx_next;
  wire hbvef_vec_t tx_next;

  assign pend = buffer_interrupt_flag & buffer_interrupt_enable;
  assign rx_next = lowest_idx(pend & buf_is_rx);
  assign tx_next = lowest_idx(pend & ~buf_is_rx);

  // load on microtick
  // leaving configuration wins so stale vectors never survive
  assign rxv_d = config_exit ? `HBVEF_VEC_RST : (utick ? rx_next : rxv_q);
  assign txv_d = config_exit ? `HBVEF_VEC_RST : (utick ? tx_next : txv_q);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rxv_q <= `HBVEF_VEC_RST;
      txv_q <= `HBVEF_VEC_RST;
    end else begin
      rxv_q <= rxv_d;
      txv_q <= txv_d;
    end
  end

  // ----------------------------------------
  // host address decode
  // ----------------------------------------
  wire logic acc = host_rd | host_wr;
  wire logic in_rsv = (host_addr >= `HBVEF_RSV_LO) && (host_addr <= `HBVEF_RSV_HI);
  wire logic bad_acc = acc & (host_byte | host_addr[0] | in_rsv);
  wire logic hit_err = (host_addr == `HBVEF_OFF_ERR);
  wire logic hit_rxv = (host_addr == `HBVEF_OFF_RXV);
  wire logic hit_txv = (host_addr == `HBVEF_OFF_TXV);
  hbvef_word_t err_q;
  hbvef_word_t rd_word;

  assign rd_word = bad_acc ? `HBVEF_RD_ZERO :
                   hit_err ? err_q :
                   hit_rxv ? {10'h000, rxv_q} :
                   hit_txv ? {10'h000, txv_q} : `HBVEF_RD_ZERO;

  // ----------------------------------------
  // lock checks, first refusal cause only
  // ----------------------------------------
  // busy buffer refused
  wire logic rf_busy = lock_req & lock_dev_busy;
  wire logic rf_dbl = lock_req & ~rf_busy & lock_double_dev_part;
  // one cause per request, so the host can tell why it was refused
  wire logic pre_fifo = ~(lock_dev_busy | lock_double_dev_part);
  wire logic rf_fbl = lock_req & pre_fifo & lock_fifo & ~lock_via_buf0;
  wire logic rf_efl = lock_req & pre_fifo & lock_fifo & lock_via_buf0 & fifo_empty;
  wire logic pre_cnt = pre_fifo & ~(lock_fifo & (~lock_via_buf0 | fifo_empty));
  wire logic rf_rbl = lock_req & pre_cnt & lock_to_rx & host_rx_held;
  wire logic rf_tbl = lock_req & pre_cnt & lock_to_tx & host_tx_held;

  assign lock_grant = lock_req & ~(rf_busy | rf_dbl | rf_fbl | rf_efl | rf_rbl | rf_tbl);

  // ----------------------------------------
  // reconfiguration, length and window checks
  // ----------------------------------------
  // dynamic to static ignored
  wire logic ev_rcfg = reconfig_req & reconfig_from_dyn & reconfig_to_static;
  assign reconfig_accept = reconfig_req & ~ev_rcfg;

  wire logic ev_mdp = plen_wr & plen_dynamic & (plen_value > dynamic_payload_limit);
  wire logic ev_spl = plen_wr & ~plen_dynamic & (plen_value != static_payload_length);
  assign plen_accept = plen_wr & ~ev_mdp & ~ev_spl;

  wire logic ev_bul = win_access & ~win_locked;
  assign win_allow = win_access & win_locked;

  // ----------------------------------------
  // received frame checks
  // ----------------------------------------
  logic lost_arm_q;
  wire logic ev_lost = rx_frame_valid & rx_target_locked & lost_arm_q;
  assign frame_discard_first = ev_lost;

  // arm after the first frame, disarm when the host lets go
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lost_arm_q <= 1'b0;
    end else begin
      lost_arm_q <= host_rx_held & (lost_arm_q | (rx_frame_valid & rx_target_locked));
    end
  end

  wire logic ev_nms = nm_frame & nm_too_short;
  wire logic ev_nmn = nm_frame & nm_null;
  assign nm_apply = nm_frame & ~nm_null;

  // ----------------------------------------
  // error flags, write one to clear
  // ----------------------------------------
  hbvef_word_t set_vec, clr_vec, err_d;

  always_comb begin
    set_vec = `HBVEF_ERR_RST;
    set_vec[`HBVEF_B_LOST] = ev_lost;
    set_vec[`HBVEF_B_RCFG] = ev_rcfg;
    set_vec[`HBVEF_B_BUSY] = rf_busy;
    set_vec[`HBVEF_B_DBL] = rf_dbl;
    set_vec[`HBVEF_B_RBL] = rf_rbl;
    set_vec[`HBVEF_B_TBL] = rf_tbl;
    set_vec[`HBVEF_B_FBL] = rf_fbl;
    set_vec[`HBVEF_B_EFL] = rf_efl;
    set_vec[`HBVEF_B_BUL] = ev_bul;
    set_vec[`HBVEF_B_MDP] = ev_mdp;
    set_vec[`HBVEF_B_SPL] = ev_spl;
    set_vec[`HBVEF_B_NMS] = ev_nms;
    set_vec[`HBVEF_B_NMN] = ev_nmn;
    set_vec[`HBVEF_B_ILA] = bad_acc;
  end

  assign clr_vec = (host_wr & ~bad_acc & hit_err) ? (host_wdata & `HBVEF_ERR_MASK)
                                                 : `HBVEF_ERR_RST;

  // reserved bits 2 and 5 can never hold a one
  localparam hbvef_word_t err_mask = `HBVEF_ERR_MASK;

  generate
    for (genvar b = 0; b < `HBVEF_ERR_W; b++) begin : g_flag
      assign err_d[b] = err_mask[b] & ((err_q[b] & ~clr_vec[b]) | set_vec[b]);
    end
  endgenerate

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      err_q <= `HBVEF_ERR_RST;
    end else begin
      err_q <= err_d & `HBVEF_ERR_MASK;
    end
  end

  assign host_interface_error_irq_flag = |(set_vec & `HBVEF_ERR_MASK);

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  hbvef_word_t rdata_q;
  logic rack_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= `HBVEF_RD_ZERO;
      rack_q <= 1'b0;
    end else begin
      rdata_q <= host_rd ? rd_word : rdata_q;
      rack_q <= host_rd;
    end
  end

  assign host_rdata = rdata_q;
  assign host_rack = rack_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  rx_vec_load_a: assert property (utick && !config_exit |=> rxv_q == $past(rx_next))
    else $error("receive vector not loaded from pending flags");
  tx_vec_load_a: assert property (utick && !config_exit |=> txv_q == $past(tx_next))
    else $error("transmit vector not loaded from pending flags");
  vec_hold_a: assert property (!utick && !config_exit |=> $stable(rxv_q) && $stable(txv_q))
    else $error("vector changed without a microtick");
  vec_none_a: assert property (utick && !config_exit && (pend == '0)
                               |=> rxv_q == 6'h00 && txv_q == 6'h00)
    else $error("vector not zero with nothing pending");
  vec_cfg_clear_a: assert property (config_exit |=> rxv_q == 6'h00 && txv_q == 6'h00)
    else $error("vector survived leaving configuration");
  err_w1c_a: assert property (clr_vec[0] && !set_vec[0] |=> !err_q[0])
    else $error("frame-lost flag not cleared by write one");
  err_set_wins_a: assert property (set_vec[`HBVEF_B_ILA] |=> err_q[`HBVEF_B_ILA])
    else $error("illegal-address flag lost against clear");
  err_keep_a: assert property (err_q[1] && !clr_vec[1] |=> err_q[1])
    else $error("flag dropped without a clear");
  err_rsv_a: assert property (err_q[2] == 1'b0 && err_q[5] == 1'b0)
    else $error("reserved error bit set");
  irq_flag_a: assert property (host_interface_error_irq_flag == (set_vec != '0))
    else $error("interrupt flag not tied to error events");
  lock_busy_a: assert property (lock_req && lock_dev_busy |-> !lock_grant ##1 err_q[3])
    else $error("busy buffer lock not refused and flagged");
  lock_rx_a: assert property (lock_req && !lock_dev_busy && !lock_double_dev_part && !lock_fifo
                              && lock_to_rx && host_rx_held |-> !lock_grant ##1 err_q[6])
    else $error("second receive lock not refused");
  lock_empty_a: assert property (lock_req && pre_fifo && lock_fifo && lock_via_buf0 && fifo_empty
                                 |-> !lock_grant ##1 err_q[`HBVEF_B_EFL])
    else $error("empty fifo lock not refused");
  plen_dyn_a: assert property (ev_mdp |-> !plen_accept ##1 err_q[`HBVEF_B_MDP])
    else $error("oversized dynamic length accepted");
  win_block_a: assert property (win_access && !win_locked |-> !win_allow ##1 err_q[10])
    else $error("unlocked window access allowed");
  nm_null_a: assert property (nm_frame && nm_null |-> !nm_apply ##1 err_q[14])
    else $error("null management frame applied");
  lost_a: assert property (rx_frame_valid && rx_target_locked && host_rx_held ##1
                           rx_frame_valid && rx_target_locked |-> frame_discard_first)
    else $error("second locked frame not flagged as lost");
  rsv_read_a: assert property (host_rd && in_rsv |=> host_rdata == 16'h0000 && err_q[15])
    else $error("reserved read not zero or not flagged");
  lock_dbl_a: assert property (lock_req && !lock_dev_busy && lock_double_dev_part
                               |-> !lock_grant ##1 err_q[4])
    else $error("lock on device half of double buffer not refused");
  lock_tx_a: assert property (lock_req && !lock_dev_busy && !lock_double_dev_part && !lock_fifo
                              && lock_to_tx && host_tx_held |-> !lock_grant ##1 err_q[7])
    else $error("second transmit lock not refused");
  lock_fifo_a: assert property (lock_req && !lock_dev_busy && !lock_double_dev_part && lock_fifo
                                && !lock_via_buf0 |-> !lock_grant ##1 err_q[8])
    else $error("fifo lock outside buffer 0 not refused");
  reconfig_a: assert property (reconfig_req && reconfig_from_dyn && reconfig_to_static
                               |-> !reconfig_accept ##1 err_q[1])
    else $error("dynamic to static reconfiguration accepted");
  plen_static_a: assert property (plen_wr && !plen_dynamic
                                  && plen_value != static_payload_length
                                  |-> !plen_accept ##1 err_q[12])
    else $error("mismatched static length accepted");
  nm_short_a: assert property (nm_frame && nm_too_short && !nm_null
                               |-> nm_apply ##1 err_q[13])
    else $error("short management frame dropped or not flagged");
  first_frame_a: assert property (!host_rx_held ##1 rx_frame_valid && rx_target_locked
                                  |-> !frame_discard_first)
    else $error("first frame after a fresh lock discarded");
  irq_err_a: assert property (host_interface_error_irq_flag |=> err_q != 16'h0000)
    else $error("interrupt flag raised with no error recorded");
  rack_a: assert property (host_rack == $past(host_rd))
    else $error("read answer not one cycle after the strobe");

  cover_rx_vec_c: cover property (utick ##1 rxv_q != 6'h00);
  cover_clear_c: cover property (err_q[0] ##1 clr_vec[0] ##1 !err_q[0]);
  cover_race_c: cover property (clr_vec[15] && set_vec[15]);
  cover_grant_c: cover property (lock_grant);
  cover_lost_c: cover property (frame_discard_first);

endmodule

`default_nettype wire

/* tb/hbvef_host.sv */
/*
  Host model on the parallel register port: word and byte reads and writes.
  Assumes the bench calls rd and wr, and that the port samples on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module hbvef_host
  import hbvef_pkg::*;
(
  // clock
  input wire logic core_clk,
  // request
  output hbvef_word_t host_addr,
  output hbvef_word_t host_wdata,
  output logic host_wr,
  output logic host_rd,
  output logic host_byte,
  // answer
  input wire hbvef_word_t host_rdata,
  input wire logic host_rack
);
  initial begin
    host_addr = 16'h0000;
    host_wdata = 16'h0000;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_byte = 1'b0;
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // ones clear, zeros keep
  task automatic wr(input hbvef_word_t a, input hbvef_word_t d, input logic b);
    @(posedge core_clk);
    #1;
    host_addr = a;
    host_wdata = d;
    host_byte = b;
    host_wr = 1'b1;
    @(posedge core_clk);
    #1;
    host_wr = 1'b0;
    // released lines show no stale value
    host_wdata = ~d;
    host_addr = ~a;
  endtask
  task automatic rd(input hbvef_word_t a, input logic b, output hbvef_word_t d,
                    output logic k);
    @(posedge core_clk);
    #1;
    host_addr = a;
    host_byte = b;
    host_rd = 1'b1;
    @(posedge core_clk);
    #1;
    d = host_rdata;
    k = host_rack;
    host_rd = 1'b0;
    host_addr = ~a;
  endtask
endmodule
`default_nettype wire

/* tb/hbvef_top_bench.sv */
/*
  Self-checking bench for the vector and error flag block.
  Assumes the host model drives the register port; all else is driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module hbvef_top_bench
  import hbvef_pkg::*;
;
  logic core_clk, reset, utick, config_exit, host_rx_held, ak;
  hbvef_word_t host_addr, host_wdata, host_rdata, rv;
  logic host_wr, host_rd, host_byte, host_rack;
  hbvef_bufmask_t buffer_interrupt_flag, buffer_interrupt_enable, buf_is_rx;
  hbvef_plen_t plen_value, dynamic_payload_limit, static_payload_length;
  wire logic lock_req, lock_to_rx, lock_to_tx, lock_dev_busy, lock_double_dev_part;
  wire logic lock_fifo, lock_via_buf0, fifo_empty, host_tx_held, reconfig_req;
  wire logic reconfig_from_dyn, reconfig_to_static, plen_wr, plen_dynamic;
  wire logic win_access, win_locked, rx_frame_valid, rx_target_locked;
  wire logic nm_frame, nm_null, nm_too_short;
  logic lock_grant, reconfig_accept, plen_accept, win_allow, nm_apply;
  logic frame_discard_first, host_interface_error_irq_flag;
  logic [20:0] stim;
  int failures, tests_run, err_m, cyc, seed, i;
  int vq[$];
  // ----------------------------------------
  // check cases: stimulus, output picked, expected, error bit
  // ----------------------------------------
  logic [20:0] stim_t [16] = '{21'h120000, 21'h110000, 21'h108000, 21'h10e000,
    21'h180000, 21'h141000, 21'h10c000, 21'h000e00, 21'h000180, 21'h000180,
    21'h000100, 21'h000040, 21'h000005, 21'h000006, 21'h000018, 21'h000018};
  int sel_t [16] = '{5, 5, 5, 5, 5, 5, 5, 4, 3, 3, 3, 2, 1, 1, 0, 0};
  int bit_t [16] = '{3, 4, 8, 9, 6, 7, -1, 1, 11, -1, 12, 10, 13, 14, -1, 0};
  logic [15:0] exp_t = 16'h9240;
  hbvef_word_t ia [4] = '{16'h0012, 16'h0013, 16'h0400, 16'h1ffe};
  wire [5:0] outs = {lock_grant, reconfig_accept, plen_accept, win_allow, nm_apply,
    frame_discard_first};
  assign {lock_req, lock_to_rx, lock_to_tx, lock_dev_busy, lock_double_dev_part, lock_fifo,
    lock_via_buf0, fifo_empty, host_tx_held, reconfig_req, reconfig_from_dyn,
    reconfig_to_static, plen_wr, plen_dynamic, win_access, win_locked, rx_frame_valid,
    rx_target_locked, nm_frame, nm_null, nm_too_short} = stim;

  hbvef_top dut_u (.core_clk, .reset, .host_addr, .host_wdata, .host_wr, .host_rd,
    .host_byte, .host_rdata, .host_rack, .utick, .config_exit, .buffer_interrupt_flag,
    .buffer_interrupt_enable, .buf_is_rx, .lock_req, .lock_to_rx, .lock_to_tx,
    .lock_dev_busy, .lock_double_dev_part, .lock_fifo, .lock_via_buf0, .fifo_empty,
    .host_rx_held, .host_tx_held, .lock_grant, .reconfig_req, .reconfig_from_dyn,
    .reconfig_to_static, .reconfig_accept, .plen_wr, .plen_dynamic, .plen_value,
    .dynamic_payload_limit, .static_payload_length, .plen_accept, .win_access,
    .win_locked, .win_allow, .rx_frame_valid, .rx_target_locked, .frame_discard_first,
    .nm_frame, .nm_null, .nm_too_short, .nm_apply, .host_interface_error_irq_flag);
  hbvef_host host_u (.core_clk, .host_addr, .host_wdata, .host_wr, .host_rd, .host_byte,
    .host_rdata, .host_rack);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // hang guard, far above the few hundred cycles used
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic results();
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input hbvef_word_t seen, input hbvef_word_t exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic rdc(input hbvef_word_t a, input logic b, input hbvef_word_t exp);
    host_u.rd(a, b, rv, ak);
    chk({15'h0, ak}, 16'h0001);
    chk(rv, exp);
  endtask
  function automatic hbvef_bufmask_t rnd();
    return 59'({$random(seed), $random(seed)});
  endfunction
  // zero doubles as none; the direction flag only picks which vector
  function automatic hbvef_word_t low(input logic rx);
    for (int n = 0; n < 59; n++)
      if (buffer_interrupt_flag[n] && buffer_interrupt_enable[n] && buf_is_rx[n] == rx)
        return 16'(n);
    return 16'h0000;
  endfunction
  task automatic fire(input int k);
    tick();
    host_rx_held = (k == 4) || (k > 13);
    stim = stim_t[k];
    plen_value = (k == 8) ? dynamic_payload_limit + 7'h01 :
      (k == 9) ? dynamic_payload_limit : static_payload_length ^ 7'h01;
    #1;
    chk({15'h0, outs[sel_t[k]]}, {15'h0, exp_t[k]});
    chk({15'h0, host_interface_error_irq_flag}, {15'h0, bit_t[k] >= 0});
    tick();
    stim = 21'h0;
    if (bit_t[k] >= 0) err_m = err_m | (1 << bit_t[k]);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 41442;
    reset = 1'b1;
    utick = 1'b0;
    config_exit = 1'b0;
    host_rx_held = 1'b0;
    stim = 21'h0;
    plen_value = 7'h00;
    buffer_interrupt_flag = '0;
    buffer_interrupt_enable = '0;
    buf_is_rx = '0;
    dynamic_payload_limit = 7'($random(seed)) & 7'h3f;
    static_payload_length = 7'($random(seed));
    repeat (6) @(posedge core_clk);
    #1;
    reset = 1'b0;
    rdc(16'h0012, 1'b0, 16'h0000);
    rdc(16'h0024, 1'b0, 16'h0000);
    rdc(16'h0026, 1'b0, 16'h0000);
    for (i = 0; i < 24; i++) begin
      tick();
      buffer_interrupt_flag = (i == 0) ? '0 : rnd();
      buffer_interrupt_enable = rnd() & rnd();
      buf_is_rx = rnd();
      utick = 1'b1;
      tick();
      utick = 1'b0;
      vq.push_back(low(1'b1));
      vq.push_back(low(1'b0));
      rdc(16'h0024, 1'b0, 16'(vq.pop_front()));
      rdc(16'h0026, 1'b0, 16'(vq.pop_front()));
    end
    tick();
    config_exit = 1'b1;
    tick();
    config_exit = 1'b0;
    rdc(16'h0024, 1'b0, 16'h0000);
    rdc(16'h0026, 1'b0, 16'h0000);
    err_m = 0;
    for (i = 0; i < 16; i++) begin
      fire(i);
      rdc(16'h0012, 1'b0, 16'(err_m));
    end
    host_rx_held = 1'b0;
    fork
      host_u.wr(16'h0012, 16'hffff, 1'b0);
      fire(0);
    join
    rdc(16'h0012, 1'b0, 16'h0008);
    host_u.wr(16'h0012, 16'h0000, 1'b0);
    rdc(16'h0012, 1'b0, 16'h0008);
    host_u.wr(16'h0012, 16'hffff, 1'b0);
    rdc(16'h0012, 1'b0, 16'h0000);
    for (i = 0; i < 4; i++) begin
      rdc(ia[i], i == 0, 16'h0000);
      rdc(16'h0012, 1'b0, 16'h8000);
      host_u.wr(16'h0012, 16'h8000, 1'b0);
    end
    host_u.wr(16'h0400, 16'hffff, 1'b0);
    host_u.wr(16'h0012, 16'hffff, 1'b1);
    rdc(16'h0400, 1'b0, 16'h0000);
    rdc(16'h0012, 1'b0, 16'h8000);
    host_u.wr(16'h0012, 16'h8000, 1'b0);
    rdc(16'h0030, 1'b0, 16'h0000);
    rdc(16'h0012, 1'b0, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
